// File: hw/spi_xfer_pkg.sv
// Constants, field layouts and types of the SPI transfer engine
package spi_xfer_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] TXD_OFS = 8'h08;
	localparam logic [7:0] RXD_OFS = 8'h0c;
	localparam logic [7:0] BAUD_OFS = 8'h10;
	localparam logic [7:0] DLY_OFS = 8'h14;
	localparam logic [7:0] EN_OFS = 8'h18;

	// Control register bit positions
	localparam int MASTER_BIT = 0;
	localparam int CPOL_BIT = 1;
	localparam int CPHA_BIT = 2;
	localparam int ORDER_BIT = 3;
	localparam int TXDMA_EN_BIT = 4;
	localparam int RXDMA_EN_BIT = 5;
	localparam int RXDMA_IE_BIT = 17;
	localparam int TXDMA_IE_BIT = 18;
	localparam logic [31:0] CTRL_MASK = 32'h0006_003f;

	// Status register bit positions
	localparam int RRDY_BIT = 0;
	localparam int TRDY_BIT = 1;
	localparam int TXIDLE_BIT = 2;
	localparam int RXDMA_DONE_BIT = 8;
	localparam int TXDMA_DONE_BIT = 9;

	// Reset values and fixed figures
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] BAUD_RST = 16'h00ff;
	localparam logic [7:0] DUMMY_BYTE = 8'hff;
	localparam logic [3:0] LAST_HALF = 4'hf;
	localparam logic [2:0] LAST_BIT = 3'h7;

	// Delay lengths, each counted in serial clock periods
	typedef struct packed {
		logic [7:0] stopLength;
		logic [7:0] burstLength;
		logic [7:0] startLength;
	} delay_len_s;
	localparam delay_len_s DLY_RST = 24'h01_01_01;

	// Pin levels as sampled from the outside
	typedef struct packed {
		logic sck;
		logic ssN;
		logic mosi;
		logic miso;
	} pins_s;

	// Master sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_XFER = 3'b010,
		ST_BURST = 3'b011,
		ST_STOP = 3'b100
	} mstate_e;

endpackage

// File: hw/spi_transfer_and_dma_handshake.sv
// SPI transfer engine with Wishbone registers and DMA handshake
`timescale 1ns/1ps
module spi_transfer_and_dma_handshake
	import spi_xfer_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic sckIn,
	output logic sckOut,
	output logic sckOe,
	input wire logic ssIn_n,
	output logic ssOut_n,
	output logic ssOe,
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOe,
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOe,
	output logic txDmaReq,
	input wire logic txDmaAck,
	input wire logic txDmaDone,
	output logic rxDmaReq,
	input wire logic rxDmaAck,
	input wire logic rxDmaDone,
	output logic dmaIrq
);

	////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [31:0] ctrl_reg;
	logic spi_enable_control_reg;
	delay_len_s spi_delay_lengths_reg;
	logic [15:0] baud_reg;
	logic [7:0] txBuf_reg;
	logic txFull_reg;
	logic [7:0] rxBuf_reg;
	logic rxFull_reg;
	logic [7:0] txShift_reg;
	logic txBit_reg;
	logic [7:0] rxShift_reg;
	logic [2:0] rxBitCnt_reg;
	logic rxDoneFlag_reg;
	logic txDoneFlag_reg;
	logic txArmed_reg;
	logic rxArmed_reg;
	pins_s sync1_reg;
	pins_s sync2_reg;
	logic sckPrev_reg;
	logic ssPrev_reg;
	logic loadPend_reg;
	mstate_e state_reg;
	logic [14:0] divCnt_reg;
	logic [3:0] halfCnt_reg;
	logic [8:0] delayCnt_reg;

	logic access, wrEn, rdEn;
	logic isMaster, cpol, cpha, lsbFirst;
	logic txDmaEn, rxDmaEn;
	logic [14:0] halfLen;
	logic tick, mStart, mEnterByte, mNextHalf, mSample, mShift;
	logic sckEdge, activeEdge, inactiveEdge, selected, ssFall, sShiftEdge;
	logic sSample, sShift, sLoad;
	logic load, shift, sample, sampleIn, byteDone;
	logic [7:0] loadByte;
	logic [7:0] startLen, burstLen, stopLen;
	logic [31:0] baudMerged, dlyMerged;

	// Merge written byte lanes into an old register value
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = val[i*8 +: 8];
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave: one wait state, every address acknowledged

	assign access = cyc_i & stb_i & ~ack_o;
	assign wrEn = access & we_i;
	assign rdEn = access & ~we_i;

	// Ack drops the cycle after it is given
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= access;
		end
	end

	// Read data; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dat_o <= 32'h0000_0000;
		end else if (rdEn) begin
			dat_o <= 32'h0000_0000;
			case ({adr_i[7:2], 2'b00})
				CTRL_OFS: dat_o <= ctrl_reg;
				STAT_OFS: begin
					dat_o[RRDY_BIT] <= rxFull_reg;
					dat_o[TRDY_BIT] <= ~txFull_reg;
					dat_o[TXIDLE_BIT] <= (state_reg == ST_IDLE) & ~txFull_reg;
					dat_o[RXDMA_DONE_BIT] <= rxDoneFlag_reg;
					dat_o[TXDMA_DONE_BIT] <= txDoneFlag_reg;
				end
				RXD_OFS: dat_o[7:0] <= rxBuf_reg;
				BAUD_OFS: dat_o[15:0] <= baud_reg;
				DLY_OFS: dat_o[23:0] <= spi_delay_lengths_reg;
				EN_OFS: dat_o[0] <= spi_enable_control_reg;
				default: dat_o <= 32'h0000_0000;
			endcase
		end
	end

	// Merged write values for the narrow registers; a zero baud is caught by the half period floor
	assign baudMerged = laneMerge({16'h0000, baud_reg}, dat_i, sel_i);
	assign dlyMerged = laneMerge({8'h00, spi_delay_lengths_reg}, dat_i, sel_i);

	// Configuration registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RST;
			spi_enable_control_reg <= 1'b0;
			spi_delay_lengths_reg <= DLY_RST;
			baud_reg <= BAUD_RST;
		end else if (wrEn) begin
			case ({adr_i[7:2], 2'b00})
				CTRL_OFS: ctrl_reg <= laneMerge(ctrl_reg, dat_i, sel_i) & CTRL_MASK;
				BAUD_OFS: baud_reg <= baudMerged[15:0];
				DLY_OFS: spi_delay_lengths_reg <= dlyMerged[23:0];
				EN_OFS: begin
					if (sel_i[0]) begin
						spi_enable_control_reg <= dat_i[0];
					end
				end
				default: ;
			endcase
		end
	end

	assign isMaster = ctrl_reg[MASTER_BIT];
	assign cpol = ctrl_reg[CPOL_BIT];
	assign cpha = ctrl_reg[CPHA_BIT];
	assign lsbFirst = ctrl_reg[ORDER_BIT];
	assign txDmaEn = ctrl_reg[TXDMA_EN_BIT];
	assign rxDmaEn = ctrl_reg[RXDMA_EN_BIT];

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: two flops before any logic looks

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_reg <= 4'b0100;
			sync2_reg <= 4'b0100;
			sckPrev_reg <= 1'b0;
			ssPrev_reg <= 1'b1;
		end else begin
			sync1_reg <= {sckIn, ssIn_n, mosiIn, misoIn};
			sync2_reg <= sync1_reg;
			sckPrev_reg <= sync2_reg.sck;
			ssPrev_reg <= sync2_reg.ssN;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shared clock generator: half period ticks

	// Baud = clk / BR, an odd BR rounded down to even; BR below two is outside the legal range
	assign halfLen = (baud_reg[15:1] == 15'h0000) ? 15'h0001 : baud_reg[15:1];
	assign tick = (state_reg != ST_IDLE) && (divCnt_reg == 15'h0000);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			divCnt_reg <= 15'h0000;
		end else if (state_reg == ST_IDLE || tick) begin
			divCnt_reg <= halfLen - 15'h0001;
		end else begin
			divCnt_reg <= divCnt_reg - 15'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master sequencer

	// A zero length would wrap the delay count to 511, so it counts as one
	assign startLen = (spi_delay_lengths_reg.startLength == 8'h00) ? 8'h01 :
		spi_delay_lengths_reg.startLength;
	assign burstLen = (spi_delay_lengths_reg.burstLength == 8'h00) ? 8'h01 :
		spi_delay_lengths_reg.burstLength;
	assign stopLen = (spi_delay_lengths_reg.stopLength == 8'h00) ? 8'h01 :
		spi_delay_lengths_reg.stopLength;

	// Own select input is ignored as master; the system keeps it high
	assign mStart = (state_reg == ST_IDLE) & spi_enable_control_reg & isMaster & txFull_reg;
	assign mEnterByte = tick & (state_reg == ST_START || state_reg == ST_BURST) & (delayCnt_reg == 9'h000);
	assign mNextHalf = tick & (state_reg == ST_XFER) & (halfCnt_reg != LAST_HALF);
	assign mSample = mNextHalf & ~halfCnt_reg[0];
	assign mShift = mNextHalf & halfCnt_reg[0];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			halfCnt_reg <= 4'h0;
			delayCnt_reg <= 9'h000;
		end else if (!spi_enable_control_reg || !isMaster) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (mStart) begin
						state_reg <= ST_START;
						delayCnt_reg <= {startLen, 1'b0} - 9'h001;
					end
				end
				ST_START, ST_BURST: begin
					if (mEnterByte) begin
						state_reg <= ST_XFER;
						halfCnt_reg <= 4'h0;
					end else if (tick) begin
						delayCnt_reg <= delayCnt_reg - 9'h001;
					end
				end
				ST_XFER: begin
					if (tick) begin
						if (halfCnt_reg != LAST_HALF) begin
							halfCnt_reg <= halfCnt_reg + 4'h1;
						end else if (txFull_reg) begin
							state_reg <= ST_BURST;
							delayCnt_reg <= {burstLen, 1'b0} - 9'h001;
						end else begin
							state_reg <= ST_STOP;
							delayCnt_reg <= {stopLen, 1'b0} - 9'h001;
						end
					end
				end
				ST_STOP: begin
					if (tick) begin
						if (delayCnt_reg == 9'h000) begin
							state_reg <= ST_IDLE;
						end else begin
							delayCnt_reg <= delayCnt_reg - 9'h001;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Master pins; clock level follows the half period and polarity
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sckOut <= 1'b0;
			ssOut_n <= 1'b1;
			sckOe <= 1'b0;
			ssOe <= 1'b0;
			mosiOe <= 1'b0;
		end else begin
			sckOe <= spi_enable_control_reg & isMaster;
			ssOe <= spi_enable_control_reg & isMaster;
			mosiOe <= spi_enable_control_reg & isMaster;
			ssOut_n <= ~(mStart | (state_reg != ST_IDLE && !(state_reg == ST_STOP && tick &&
				delayCnt_reg == 9'h000)));
			if (mEnterByte) begin
				sckOut <= cpol ^ cpha;
			end else if (mNextHalf) begin
				sckOut <= ~sckOut;
			end else if (state_reg != ST_XFER || tick) begin
				sckOut <= cpol;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Slave edge decoding from the sampled clock and select

	assign sckEdge = sync2_reg.sck != sckPrev_reg;
	assign activeEdge = sckEdge & (sync2_reg.sck != cpol);
	assign inactiveEdge = sckEdge & (sync2_reg.sck == cpol);
	assign selected = spi_enable_control_reg & ~isMaster & ~sync2_reg.ssN;
	assign ssFall = ssPrev_reg & ~sync2_reg.ssN & spi_enable_control_reg & ~isMaster;
	assign sSample = selected & (cpha ? inactiveEdge : activeEdge);
	assign sShiftEdge = selected & (cpha ? activeEdge : inactiveEdge);
	assign sLoad = (ssFall & ~cpha) | (sShiftEdge & loadPend_reg);
	assign sShift = sShiftEdge & ~loadPend_reg;

	// Load waits for the shift edge after a finished byte; phase zero loads at the select edge itself, a phase-one select pends no load
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			loadPend_reg <= 1'b0;
		end else if (!selected) begin
			loadPend_reg <= ssFall & cpha;
		end else if (sLoad) begin
			loadPend_reg <= 1'b0;
		end else if (byteDone) begin
			loadPend_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			misoOe <= 1'b0;
		end else begin
			misoOe <= selected;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Transmit path: holding buffer plus shifter

	assign load = mEnterByte | sLoad;
	assign shift = mShift | sShift;
	// Empty buffer at load time sends filler, e.g. a slave's first DMA byte
	assign loadByte = txFull_reg ? txBuf_reg : DUMMY_BYTE;

	// Write after load keeps the buffer full with the new byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txBuf_reg <= 8'h00;
			txFull_reg <= 1'b0;
		end else begin
			if (load) begin
				txFull_reg <= 1'b0;
			end
			if (wrEn && {adr_i[7:2], 2'b00} == TXD_OFS && sel_i[0]) begin
				txBuf_reg <= dat_i[7:0];
				txFull_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txShift_reg <= 8'h00;
			txBit_reg <= 1'b0;
		end else if (load) begin
			txShift_reg <= loadByte;
			txBit_reg <= lsbFirst ? loadByte[0] : loadByte[7];
		end else if (shift) begin
			txShift_reg <= lsbFirst ? (txShift_reg >> 1) : (txShift_reg << 1);
			txBit_reg <= lsbFirst ? txShift_reg[1] : txShift_reg[6];
		end
	end

	assign mosiOut = txBit_reg;
	assign misoOut = txBit_reg;

	////////////////////////////////////////////////////////////////////////
	// Receive path: shifter plus holding buffer

	assign sample = mSample | sSample;
	assign sampleIn = isMaster ? sync2_reg.miso : sync2_reg.mosi;
	assign byteDone = sample & (rxBitCnt_reg == LAST_BIT);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxShift_reg <= 8'h00;
			rxBitCnt_reg <= 3'h0;
		end else if (load) begin
			rxBitCnt_reg <= 3'h0;
		end else if (sample) begin
			rxShift_reg <= lsbFirst ? {sampleIn, rxShift_reg[7:1]} : {rxShift_reg[6:0], sampleIn};
			rxBitCnt_reg <= rxBitCnt_reg + 3'h1;
		end
	end

	// New byte wins over a read in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxBuf_reg <= 8'h00;
			rxFull_reg <= 1'b0;
		end else begin
			if (rdEn && {adr_i[7:2], 2'b00} == RXD_OFS) begin
				rxFull_reg <= 1'b0;
			end
			if (byteDone) begin
				rxBuf_reg <= lsbFirst ? {sampleIn, rxShift_reg[7:1]} : {rxShift_reg[6:0], sampleIn};
				rxFull_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// DMA handshake, one independent channel per direction

	// Rearm only after the buffer changes state, so one request per byte
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txDmaReq <= 1'b0;
			txArmed_reg <= 1'b1;
		end else if (!txDmaEn) begin
			txDmaReq <= 1'b0;
			txArmed_reg <= 1'b1;
		end else if (txDmaReq) begin
			if (txDmaAck) begin
				txDmaReq <= 1'b0;
				txArmed_reg <= 1'b0;
			end
		end else if (txFull_reg) begin
			txArmed_reg <= 1'b1;
		end else if (txArmed_reg) begin
			txDmaReq <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxDmaReq <= 1'b0;
			rxArmed_reg <= 1'b1;
		end else if (!rxDmaEn) begin
			rxDmaReq <= 1'b0;
			rxArmed_reg <= 1'b1;
		end else if (rxDmaReq) begin
			if (rxDmaAck) begin
				rxDmaReq <= 1'b0;
				rxArmed_reg <= 1'b0;
			end
		end else if (!rxFull_reg) begin
			rxArmed_reg <= 1'b1;
		end else if (rxArmed_reg) begin
			rxDmaReq <= 1'b1;
		end
	end

	// Done flags: zero while disabled, write one clears, set wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rxDoneFlag_reg <= 1'b0;
			txDoneFlag_reg <= 1'b0;
		end else begin
			if (wrEn && {adr_i[7:2], 2'b00} == STAT_OFS && sel_i[1]) begin
				if (dat_i[RXDMA_DONE_BIT]) begin
					rxDoneFlag_reg <= 1'b0;
				end
				if (dat_i[TXDMA_DONE_BIT]) begin
					txDoneFlag_reg <= 1'b0;
				end
			end
			if (!rxDmaEn) begin
				rxDoneFlag_reg <= 1'b0;
			end else if (rxDmaDone) begin
				rxDoneFlag_reg <= 1'b1;
			end
			if (!txDmaEn) begin
				txDoneFlag_reg <= 1'b0;
			end else if (txDmaDone) begin
				txDoneFlag_reg <= 1'b1;
			end
		end
	end

	// Done interrupt gated by the two enables
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dmaIrq <= 1'b0;
		end else begin
			dmaIrq <= (rxDoneFlag_reg & ctrl_reg[RXDMA_IE_BIT]) |
				(txDoneFlag_reg & ctrl_reg[TXDMA_IE_BIT]);
		end
	end

endmodule

// File: verification/spi_xfer_checker.sv
// Port-level assertions for the SPI transfer engine
`timescale 1ns/1ps
module spi_xfer_checker
	import spi_xfer_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	input wire logic sckOut,
	input wire logic sckOe,
	input wire logic ssOut_n,
	input wire logic txDmaReq,
	input wire logic txDmaAck,
	input wire logic txDmaDone,
	input wire logic rxDmaReq,
	input wire logic rxDmaAck,
	input wire logic rxDmaDone,
	input wire logic dmaIrq
);
	logic [31:0] ctrlReg;
	logic txPend;
	logic [7:0] edgeCnt;
	logic wrAcc;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	// Accepted write, seen at the same edge the engine takes it
	assign wrAcc = cyc_i && stb_i && we_i && !ack_o;
	// Shadow control bits; lane masks ignored, bench writes whole words
	always_ff @(posedge clk) begin
		if (!rst_n) ctrlReg <= '0;
		else if (wrAcc && adr_i[7:2] == CTRL_OFS[7:2]) ctrlReg <= dat_i;
	end
	// A frame may only open after a fresh transmit write
	always_ff @(posedge clk) begin
		if (!rst_n) txPend <= 1'b0;
		else if (wrAcc && adr_i[7:2] == TXD_OFS[7:2]) txPend <= 1'b1;
		else if (!ssOut_n) txPend <= 1'b0;
	end
	// Serial clock toggles within one frame
	always_ff @(posedge clk) begin
		if (!rst_n || ssOut_n) edgeCnt <= 8'h00;
		else if (sckOut != $past(sckOut)) edgeCnt <= edgeCnt + 8'h01;
	end
	////////////////////////////////////////////////////////////////////////////////
	sequence txHandshake;
		txDmaReq && txDmaAck;
	endsequence
	sequence rxHandshake;
		rxDmaReq && rxDmaAck;
	endsequence
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held over one cycle");
	ack_latency_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing after request");
	sck_idle_a: assert property (ssOut_n && sckOe && $past(sckOe) && ctrlReg[CPOL_BIT] == $past(ctrlReg[CPOL_BIT], 2)
		|-> sckOut == ctrlReg[CPOL_BIT]) else $error("serial clock not at idle level");
	frame_start_a: assert property ($fell(ssOut_n) |-> txPend) else $error("frame without transmit write");
	frame_bytes_a: assert property ($rose(ssOut_n) |-> edgeCnt[3:0] == 4'h0 && edgeCnt != 8'h00)
		else $error("frame not whole bytes");
	tx_req_hold_a: assert property (txDmaReq && !txDmaAck |=> txDmaReq) else $error("tx request dropped");
	tx_req_drop_a: assert property (txHandshake |=> !txDmaReq) else $error("tx request kept after ack");
	rx_req_hold_a: assert property (rxDmaReq && !rxDmaAck |=> rxDmaReq) else $error("rx request dropped");
	rx_req_drop_a: assert property (rxHandshake |=> !rxDmaReq) else $error("rx request kept after ack");
	tx_done_irq_a: assert property (txDmaDone && ctrlReg[TXDMA_EN_BIT] && ctrlReg[TXDMA_IE_BIT] |-> ##[1:3] dmaIrq)
		else $error("no irq after tx done");
	rx_done_irq_a: assert property (rxDmaDone && ctrlReg[RXDMA_EN_BIT] && ctrlReg[RXDMA_IE_BIT] |-> ##[1:3] dmaIrq)
		else $error("no irq after rx done");
endmodule

// File: verification/spi_far_model.sv
// Far-side SPI party: slave to the engine as master, or master to it as slave
`timescale 1ns/1ps
module spi_far_model (
	input wire logic clk,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [7:0] reply,
	input wire logic sck,
	input wire logic ss_n,
	input wire logic mosi,
	input wire logic miso,
	output logic sckDrv,
	output logic ssDrv_n,
	output logic mosiDrv,
	output logic misoDrv,
	output logic [7:0] got,
	output logic firstMiso
);
	logic [7:0] sh, rx, mb;
	logic playing;
	int cnt;
	// Own select held high while the engine is master
	initial begin
		sckDrv = 1'b0;
		ssDrv_n = 1'b1;
		mosiDrv = 1'b0;
		misoDrv = 1'b0;
		playing = 1'b0;
	end
	task automatic sample();
		rx = {rx[6:0], mosi};
		cnt++;
		if (cnt == 8) begin
			cnt = 0;
			sh = reply;
			got = rx;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Selected: load reply; phase zero shows its first bit at once
	always @(negedge ss_n) begin
		cnt = 0;
		sh = reply;
		if (!cpha && !playing) misoDrv = sh[7];
	end
	// Released line shows the inverse, never a stale copy
	always @(posedge ss_n) misoDrv = ~misoDrv;
	// Serial edges from the engine as master
	always @(sck) begin
		if (!ss_n && !playing) begin
			if (sck != cpol) begin
				if (cpha) begin
					misoDrv = sh[7];
					sh = sh << 1;
				end else sample();
			end else if (cpha) sample();
			else begin
				if (cnt != 0) sh = sh << 1;
				misoDrv = sh[7];
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Master for one phase-zero byte; 160 ns period, offset from clk edges
	task automatic masterByte(input logic [7:0] b);
		@(posedge clk);
		#7;
		playing = 1'b1;
		mb = b;
		sckDrv = cpol;
		ssDrv_n = 1'b0;
		mosiDrv = mb[7];
		#80;
		firstMiso = miso;
		for (int i = 0; i < 8; i++) begin
			sckDrv = ~cpol;
			rx = {rx[6:0], miso};
			#80;
			sckDrv = cpol;
			mb = mb << 1;
			mosiDrv = mb[7];
			#80;
		end
		ssDrv_n = 1'b1;
		mosiDrv = ~mosiDrv;
		got = rx;
		playing = 1'b0;
	endtask
endmodule

// File: verification/spi_transfer_and_dma_handshake_tb_top.sv
// Testbench top: registers, transfers in all modes, DMA handshake, slave mode
`timescale 1ns/1ps
module spi_transfer_and_dma_handshake_tb_top
	import spi_xfer_pkg::*;
;
	logic clk, rst_n, cyc, stb, we, ack, txDmaReq, txDmaAck, txDmaDone, rxDmaReq, rxDmaAck, rxDmaDone, dmaIrq;
	logic [7:0] adr, reply, got;
	logic [3:0] sel;
	logic [31:0] datI, datO, q;
	logic sckOut, sckOe, ssOut_n, ssOe, mosiOut, mosiOe, misoOut, misoOe, pSck, pSs_n, pMosi, pMiso;
	logic pCpol, pCpha, firstMiso;
	int miscompares, checkCount, frames, f;
	time tFall;
	// Pin levels resolved from the engine's output enables
	wire sckW = sckOe ? sckOut : pSck;
	wire ssW_n = ssOe ? ssOut_n : pSs_n;
	wire mosiW = mosiOe ? mosiOut : pMosi;
	wire misoW = misoOe ? misoOut : pMiso;
	spi_transfer_and_dma_handshake spi_transfer_and_dma_handshake_inst (.clk(clk), .rst_n(rst_n), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack), .sckIn(sckW),
		.sckOut(sckOut), .sckOe(sckOe), .ssIn_n(ssW_n), .ssOut_n(ssOut_n), .ssOe(ssOe), .mosiIn(mosiW),
		.mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe), .txDmaReq(txDmaReq),
		.txDmaAck(txDmaAck), .txDmaDone(txDmaDone), .rxDmaReq(rxDmaReq), .rxDmaAck(rxDmaAck), .rxDmaDone(rxDmaDone),
		.dmaIrq(dmaIrq));
	spi_far_model spi_far_model_inst (.clk(clk), .cpol(pCpol), .cpha(pCpha), .reply(reply), .sck(sckW), .ss_n(ssW_n),
		.mosi(mosiW), .miso(misoW), .sckDrv(pSck), .ssDrv_n(pSs_n), .mosiDrv(pMosi), .misoDrv(pMiso), .got(got),
		.firstMiso(firstMiso));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Frame starts, counted and timed
	always @(negedge ssOut_n) begin
		frames++;
		tFall = $time;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Classic single cycle; held until ack is sampled, then released
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datI <= d;
		sel <= s;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1) miscompares++;
		q = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitStat(input int b);
		int n;
		n = 0;
		q = 32'h0;
		while (q[b] !== 1'b1 && n < 400) begin
			wb(1'b0, STAT_OFS, 32'h0, 4'hf);
			n++;
		end
		chk("status bit", 32'(q[b]), 32'h1);
	endtask
	// One-cycle strobe on the DMA side inputs
	task automatic pulse(input logic [3:0] v);
		{rxDmaDone, rxDmaAck, txDmaDone, txDmaAck} <= v;
		@(posedge clk);
		{rxDmaDone, rxDmaAck, txDmaDone, txDmaAck} <= 4'h0;
		repeat (3) @(posedge clk);
	endtask
	task automatic waitReq(input logic r);
		int n;
		n = 0;
		while ((r ? rxDmaReq : txDmaReq) !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic finalReport();
		$display("checks %0d miscompares %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Watchdog sized well above the expected run
	initial begin
		#1000000;
		miscompares++;
		finalReport();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, cyc, stb, we, adr, sel, datI, txDmaAck, txDmaDone, rxDmaAck, rxDmaDone} = '0;
		{pCpol, pCpha, reply} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wb(1'b0, DLY_OFS, 32'h0, 4'hf);
		chk("delay reset", q, 32'h0001_0101);
		wb(1'b0, CTRL_OFS, 32'h0, 4'hf);
		chk("ctrl reset", q, CTRL_RST);
		wb(1'b0, BAUD_OFS, 32'h0, 4'hf);
		chk("baud reset", q, {16'h0000, BAUD_RST});
		wb(1'b0, STAT_OFS, 32'h0, 4'hf);
		chk("dma flags reset", q & 32'h0000_0300, 32'h0);
		wb(1'b0, 8'h1c, 32'h0, 4'hf);
		chk("unmapped", q, 32'h0);
		wb(1'b1, DLY_OFS, 32'h00aa_bbcc, 4'h1);
		wb(1'b0, DLY_OFS, 32'h0, 4'hf);
		chk("delay lane", q, 32'h0001_01cc);
		wb(1'b1, DLY_OFS, {8'h00, DLY_RST}, 4'hf);
		wb(1'b1, BAUD_OFS, 32'h8, 4'hf);
		wb(1'b1, EN_OFS, 32'h1, 4'hf);
		// Two back-to-back bytes in each clock mode
		for (int m = 0; m < 4; m++) begin
			pCpol <= m[0];
			pCpha <= m[1];
			reply <= 8'h96 ^ 8'(m);
			wb(1'b1, CTRL_OFS, 32'(1 + 2 * m), 4'hf);
			f = frames;
			wb(1'b1, TXD_OFS, 32'h5a, 4'hf);
			waitStat(TRDY_BIT);
			wb(1'b1, TXD_OFS, 32'(8'ha5 - 8'(m)), 4'hf);
			waitStat(RRDY_BIT);
			wb(1'b0, RXD_OFS, 32'h0, 4'hf);
			chk("rx first", q, 32'(8'h96 ^ 8'(m)));
			waitStat(RRDY_BIT);
			wb(1'b0, RXD_OFS, 32'h0, 4'hf);
			chk("rx second", q, 32'(8'h96 ^ 8'(m)));
			wait (ssOut_n === 1'b1);
			@(posedge clk);
			chk("frames", 32'(frames - f), 32'h1);
			chk("tx seen", 32'(got), 32'(8'ha5 - 8'(m)));
		end
		// Start delay, phase one; zero length acts as one
		pCpol <= 1'b0;
		pCpha <= 1'b1;
		wb(1'b1, CTRL_OFS, 32'h5, 4'hf);
		for (int s = 0; s < 3; s += 2) begin
			wb(1'b1, DLY_OFS, {8'h00, 8'h01, 8'h01, 8'(s)}, 4'hf);
			wb(1'b1, TXD_OFS, 32'h33, 4'hf);
			@(sckOut);
			chk("start delay", 32'(($time - tFall) / 20), 32'(8 * (s == 0 ? 1 : s)));
			waitStat(RRDY_BIT);
			wb(1'b0, RXD_OFS, 32'h0, 4'hf);
			wait (ssOut_n === 1'b1);
			@(posedge clk);
		end
		// DMA handshake on both channels
		pCpha <= 1'b0;
		reply <= 8'h4e;
		wb(1'b1, CTRL_OFS, 32'h0006_0031, 4'hf);
		waitReq(1'b0);
		chk("tx request", 32'(txDmaReq), 32'h1);
		pulse(4'b0001);
		chk("tx request acked", 32'(txDmaReq), 32'h0);
		wb(1'b1, TXD_OFS, 32'h81, 4'hf);
		waitReq(1'b0);
		chk("tx request again", 32'(txDmaReq), 32'h1);
		waitReq(1'b1);
		chk("rx request", 32'(rxDmaReq), 32'h1);
		pulse(4'b0100);
		chk("rx request acked", 32'(rxDmaReq), 32'h0);
		wb(1'b0, RXD_OFS, 32'h0, 4'hf);
		chk("rx by dma", q, 32'h4e);
		wb(1'b0, STAT_OFS, 32'h0, 4'hf);
		chk("flags running", q & 32'h0000_0300, 32'h0);
		pulse(4'b1010);
		chk("dma irq", 32'(dmaIrq), 32'h1);
		wb(1'b0, STAT_OFS, 32'h0, 4'hf);
		chk("done flags", q & 32'h0000_0300, 32'h0000_0300);
		pulse(4'b0001);
		wait (ssOut_n === 1'b1);
		wb(1'b1, CTRL_OFS, 32'h1, 4'hf);
		wb(1'b0, STAT_OFS, 32'h0, 4'hf);
		chk("flags disabled", q & 32'h0000_0300, 32'h0);
		// Slave, phase zero; transmit loaded while disabled
		wb(1'b1, EN_OFS, 32'h0, 4'hf);
		wb(1'b1, CTRL_OFS, 32'h0, 4'hf);
		wb(1'b1, TXD_OFS, 32'hc3, 4'hf);
		wb(1'b1, EN_OFS, 32'h1, 4'hf);
		spi_far_model_inst.masterByte(8'h3c);
		chk("slave first bit", 32'(firstMiso), 32'h1);
		chk("slave tx", 32'(got), 32'hc3);
		waitStat(RRDY_BIT);
		wb(1'b0, RXD_OFS, 32'h0, 4'hf);
		chk("slave rx", q, 32'h3c);
		// Empty transmit buffer: the slave sends filler
		spi_far_model_inst.masterByte(8'h00);
		chk("slave dummy", 32'(got), 32'hff);
		finalReport();
	end
endmodule
bind spi_transfer_and_dma_handshake spi_xfer_checker spi_xfer_checker_inst (.clk(clk), .rst_n(rst_n), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .sckOut(sckOut), .sckOe(sckOe),
	.ssOut_n(ssOut_n), .txDmaReq(txDmaReq), .txDmaAck(txDmaAck), .txDmaDone(txDmaDone), .rxDmaReq(rxDmaReq),
	.rxDmaAck(rxDmaAck), .rxDmaDone(rxDmaDone), .dmaIrq(dmaIrq));
